/* File: rtl/ecpms_top.sv */
// extended port control and mode-driven transfer engine
// assumes a one-cycle strobe register port and raw pins on the port side
`timescale 1ns/1ps
`include "ecpms_cfg.svh"
module ecpms_top #(
	parameter int DEPTH  = `ECPMS_DEPTH,
	parameter int THRESH = `ECPMS_THRESH
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	// register port
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic [7:0]      reg_rdata_out,
	// dma
	output logic            dma_req_out,
	input  wire logic       dma_ack_in,
	input  wire logic       dma_tc_in,
	input  wire logic [7:0] dma_wdata_in,
	output logic [7:0]      dma_rdata_out,
	// port pins
	input  wire logic [7:0] pd_in,
	output logic [7:0]      pd_out,
	output logic            pd_oe_out,
	output logic            strobe_n_out,
	output logic            autofd_n_out,
	output logic            init_n_out,
	output logic            selectin_n_out,
	input  wire logic       busy_in,
	input  wire logic       ack_n_in,
	input  wire logic       fault_n_in,
	input  wire logic       paper_end_in,
	input  wire logic       select_in,
	// status
	output logic            epp_enable_out,
	output logic            port_irq_out
);
	localparam int CW = $clog2(DEPTH) + 1;
	localparam int NW = `ECPMS_CNT_W;
	localparam logic [CW-1:0] THR = CW'(THRESH);
	localparam int SETUP_N = `ECPMS_CYC(`ECPMS_SETUP_NS);
	localparam logic [NW-1:0] SETUP_CYC = NW'(SETUP_N);
	localparam logic [7:0] ECR_RST = `ECPMS_ECR_RESET;
	localparam logic [NW-1:0] STB_CYC = NW'(`ECPMS_CYC(`ECPMS_STROBE_NS));

	// ==========================================================
	// reset release and pin synchronisers
	logic rst_s1, rst_n;
	ecpms_pkg::ecpms_pins_t pin_s1, pin_s;
	logic fault_d;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1  <= '0;
			pin_s   <= '0;
			fault_d <= 1'b0;
		end else begin
			pin_s1  <= {pd_in, busy_in, ack_n_in, fault_n_in, paper_end_in, select_in};
			pin_s   <= pin_s1;
			fault_d <= pin_s.fault_n;
		end
	end

	// ==========================================================
	// register state and queue wiring
	ecpms_pkg::ecpms_mode_t mode, next_mode;
	ecpms_pkg::ecpms_state_t st, next_st;
	ecpms_pkg::ecpms_entry_t push_data, head;
	logic       fdis, dma_request_enable, svc, next_fdis, next_dma_request_enable, next_svc;
	logic [5:0] ctrl, next_ctrl;
	logic [7:0] data_reg, next_data_reg, rdata, next_rdata, dma_rd, next_dma_rd;
	logic       epp_sel, next_epp_sel, epp_en, next_epp_en, irq, next_irq;
	logic [NW-1:0] cnt, next_cnt;
	logic [7:0] pd_q, next_pd_q;
	logic       stb_n, next_stb_n, afd_n, next_afd_n;
	logic       push_valid, push_ready, pop_ready, pop_valid;
	logic [CW-1:0] count;
	logic       eff_dir, fifo_mode, fsm_owns, drain_fwd, ecp_rev;
	logic       host_cmd, host_dat, host_pop, dma_push, dma_pop;
	logic       fsm_push, fsm_pop, svc_evt, fault_evt;

	// direction has no effect in modes 000 and 010
	assign eff_dir   = ctrl[`ECPMS_C_DIR] && !(mode == ecpms_pkg::M_SPP || mode == ecpms_pkg::M_CFIFO);
	assign fifo_mode = mode == ecpms_pkg::M_CFIFO || mode == ecpms_pkg::M_ECP || mode == ecpms_pkg::M_TEST;
	assign fsm_owns  = mode == ecpms_pkg::M_CFIFO || mode == ecpms_pkg::M_ECP;
	assign drain_fwd = fsm_owns && !eff_dir; // see [RQ5] see [RQ6]
	assign ecp_rev   = mode == ecpms_pkg::M_ECP && eff_dir;
	assign host_cmd  = reg_wr_in && reg_addr_in == `ECPMS_A_DATA
	                   && mode == ecpms_pkg::M_ECP && !eff_dir; // see [RQ7]
	assign host_dat  = reg_wr_in && reg_addr_in == `ECPMS_A_FIFO && fifo_mode && !ecp_rev;
	assign host_pop  = reg_rd_in && reg_addr_in == `ECPMS_A_FIFO && (ecp_rev || mode == ecpms_pkg::M_TEST);
	assign dma_push  = dma_ack_in && fifo_mode && !eff_dir;
	assign dma_pop   = dma_ack_in && fifo_mode && eff_dir;
	assign dma_req_out = dma_request_enable && (eff_dir ? (fifo_mode && pop_valid)
	                                       : (fifo_mode && push_ready)); // see [RQ13]

	always_comb begin
		push_data = '{is_cmd: 1'b0, data: pin_s.pd};
		if (host_cmd)
			push_data = '{is_cmd: 1'b1, data: reg_wdata_in};
		else if (host_dat)
			push_data = '{is_cmd: 1'b0, data: reg_wdata_in};
		else if (dma_push)
			push_data = '{is_cmd: 1'b0, data: dma_wdata_in};
	end
	assign push_valid = host_cmd || host_dat || dma_push || fsm_push;
	assign pop_ready  = host_pop || dma_pop || fsm_pop;

	ecpms_fifo #(
		.WIDTH ($bits(ecpms_pkg::ecpms_entry_t)),
		.DEPTH (DEPTH)
	) u_queue (
		.clk_in         (clk_in),
		.rst_n_in       (rst_n),
		.clear_in       (mode == ecpms_pkg::M_SPP), // see [RQ2]
		.push_valid_in  (push_valid),
		.push_data_in   (push_data),
		.push_ready_out (push_ready),
		.pop_ready_in   (pop_ready),
		.pop_valid_out  (pop_valid),
		.pop_data_out   (head),
		.count_out      (count)
	);

	// ==========================================================
	// transfer engine
	always_comb begin
		next_st    = st;
		next_cnt   = cnt;
		next_pd_q  = pd_q;
		next_stb_n = stb_n;
		next_afd_n = afd_n;
		fsm_push   = 1'b0;
		fsm_pop    = 1'b0;
		case (st)
			ecpms_pkg::ST_IDLE: begin
				next_stb_n = 1'b1;
				next_afd_n = !ecp_rev;
				// test mode never starts a handshake
				if (drain_fwd && pop_valid && !pin_s.busy) begin // see [RQ10]
					fsm_pop    = 1'b1;
					next_pd_q  = head.data;
					next_afd_n = !(mode == ecpms_pkg::M_ECP && head.is_cmd); // see [RQ7]
					next_cnt   = SETUP_CYC;
					next_st    = ecpms_pkg::ST_SETUP;
				end else if (ecp_rev && !pin_s.ack_n && push_ready
				             && !(host_cmd || host_dat || dma_push)) begin
					fsm_push   = 1'b1; // see [RQ8]
					next_afd_n = 1'b1;
					next_st    = ecpms_pkg::ST_REV;
				end
			end
			ecpms_pkg::ST_SETUP: begin
				next_cnt = cnt - 1'b1;
				if (cnt <= NW'(1)) begin
					next_stb_n = 1'b0;
					next_cnt   = STB_CYC;
					next_st    = ecpms_pkg::ST_STROBE;
				end
			end
			ecpms_pkg::ST_STROBE: begin
				if (cnt != '0)
					next_cnt = cnt - 1'b1;
				// ecp waits for the peripheral ack, compat times the strobe
				if (mode == ecpms_pkg::M_ECP ? pin_s.busy : cnt <= NW'(1)) begin // see [RQ6]
					next_stb_n = 1'b1;
					next_st    = ecpms_pkg::ST_HOLD;
				end
			end
			ecpms_pkg::ST_HOLD: begin
				if (!pin_s.busy)
					next_st = ecpms_pkg::ST_IDLE; // see [RQ5]
			end
			ecpms_pkg::ST_REV: begin
				if (pin_s.ack_n) begin
					next_afd_n = 1'b0; // see [RQ8]
					next_st    = ecpms_pkg::ST_IDLE;
				end
			end
			default: begin
				next_st = ecpms_pkg::ST_IDLE;
			end
		endcase
		// leaving the handshake modes drops any transfer in flight
		if (!fsm_owns && st != ecpms_pkg::ST_IDLE) begin
			next_st    = ecpms_pkg::ST_IDLE;
			next_stb_n = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st    <= ecpms_pkg::ST_IDLE;
			cnt   <= '0;
			pd_q  <= 8'h00;
			stb_n <= 1'b1;
			afd_n <= 1'b1;
		end else begin
			st    <= next_st;
			cnt   <= next_cnt;
			pd_q  <= next_pd_q;
			stb_n <= next_stb_n;
			afd_n <= next_afd_n;
		end
	end

	// ==========================================================
	// pin drive
	assign pd_out         = fsm_owns ? pd_q : data_reg;
	assign pd_oe_out      = !eff_dir; // see [RQ3]
	assign strobe_n_out   = fsm_owns ? stb_n : !ctrl[`ECPMS_C_STB];
	assign autofd_n_out   = mode == ecpms_pkg::M_ECP ? afd_n : !ctrl[`ECPMS_C_AFD];
	assign init_n_out     = ctrl[`ECPMS_C_INIT];
	assign selectin_n_out = !ctrl[`ECPMS_C_SLIN];
	assign reg_rdata_out  = rdata;
	assign dma_rdata_out  = dma_rd;
	assign epp_enable_out = epp_en;
	assign port_irq_out   = irq;

	// ==========================================================
	// registers and events
	assign svc_evt = fifo_mode && !svc && (dma_request_enable ? dma_tc_in
	                 : (eff_dir ? count >= THR : CW'(DEPTH) - count >= THR));
	assign fault_evt = mode == ecpms_pkg::M_ECP && !fdis && fault_d && !pin_s.fault_n;

	always_comb begin
		next_mode     = mode;
		next_fdis     = fdis;
		next_dma_request_enable    = dma_request_enable;
		next_svc      = svc;
		next_ctrl     = ctrl;
		next_data_reg = data_reg;
		next_epp_sel  = epp_sel;
		next_rdata    = 8'h00;
		next_dma_rd   = dma_pop ? head.data : dma_rd;
		next_epp_en   = mode == ecpms_pkg::M_EPP && epp_sel; // see [RQ9]
		next_irq      = fault_evt || svc_evt; // see [RQ15]
		if (reg_wr_in) begin
			case (reg_addr_in)
				`ECPMS_A_DATA: next_data_reg = reg_wdata_in;
				`ECPMS_A_CTRL: next_ctrl = reg_wdata_in[5:0];
				`ECPMS_A_PCFG: next_epp_sel = reg_wdata_in[0];
				`ECPMS_A_ECR: begin
					next_mode  = ecpms_pkg::ecpms_mode_t'(reg_wdata_in[7:5]); // see [RQ1]
					next_fdis  = reg_wdata_in[`ECPMS_ECR_FDIS];
					next_dma_request_enable = reg_wdata_in[`ECPMS_ECR_DMA_REQUEST_ENABLE];
					next_svc   = reg_wdata_in[`ECPMS_ECR_SVC];
				end
				default: begin
				end
			endcase
		end
		if (svc_evt)
			next_svc = 1'b1; // see [RQ14]
		if (reg_rd_in) begin
			case (reg_addr_in)
				`ECPMS_A_DATA: next_rdata = mode == ecpms_pkg::M_BIDIR ? pin_s.pd : data_reg; // see [RQ4]
				`ECPMS_A_STATUS: next_rdata = {!pin_s.busy, pin_s.ack_n, pin_s.pe, pin_s.slct,
				                               pin_s.fault_n, `ECPMS_STAT_ONES};
				`ECPMS_A_CTRL: next_rdata = {`ECPMS_CTRL_ONES, ctrl};
				`ECPMS_A_FIFO: next_rdata = mode == ecpms_pkg::M_CONFIG ? `ECPMS_CNFGA : head.data;
				`ECPMS_A_ECR: next_rdata = {mode, fdis, dma_request_enable, svc, !push_ready, !pop_valid}; // see [RQ12]
				`ECPMS_A_PCFG: next_rdata = {7'h00, epp_sel};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode     <= ecpms_pkg::ecpms_mode_t'(ECR_RST[7:5]);
			fdis     <= ECR_RST[`ECPMS_ECR_FDIS];
			dma_request_enable    <= ECR_RST[`ECPMS_ECR_DMA_REQUEST_ENABLE];
			svc      <= ECR_RST[`ECPMS_ECR_SVC];
			ctrl     <= `ECPMS_CTRL_RST;
			data_reg <= 8'h00;
			epp_sel  <= 1'b0;
			rdata    <= 8'h00;
			dma_rd   <= 8'h00;
			epp_en   <= 1'b0;
			irq      <= 1'b0;
		end else begin
			mode     <= next_mode;
			fdis     <= next_fdis;
			dma_request_enable    <= next_dma_request_enable;
			svc      <= next_svc;
			ctrl     <= next_ctrl;
			data_reg <= next_data_reg;
			epp_sel  <= next_epp_sel;
			rdata    <= next_rdata;
			dma_rd   <= next_dma_rd;
			epp_en   <= next_epp_en;
			irq      <= next_irq;
		end
	end

	// ==========================================================
	// checks
	a_mode_write: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ1]
		reg_wr_in && reg_addr_in == `ECPMS_A_ECR |=> mode == $past(reg_wdata_in[7:5]))
		else $error("mode field did not take the written value");
	a_spp_clear: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ2]
		mode == ecpms_pkg::M_SPP |=> !pop_valid)
		else $error("queue not empty in standard mode");
	a_bidir_tristate: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ3]
		mode == ecpms_pkg::M_BIDIR && ctrl[`ECPMS_C_DIR] |-> !pd_oe_out)
		else $error("data drivers on while input selected");
	a_bidir_readback: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ4]
		reg_rd_in && reg_addr_in == `ECPMS_A_DATA && mode == ecpms_pkg::M_BIDIR
		|=> reg_rdata_out == $past(pin_s.pd))
		else $error("data read did not return line levels");
	a_cfifo_drive: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ5]
		mode == ecpms_pkg::M_CFIFO |-> pd_oe_out && strobe_n_out == stb_n)
		else $error("fifo mode not driving forward");
	a_ecp_start: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ6]
		st == ecpms_pkg::ST_IDLE && drain_fwd && pop_valid && !pin_s.busy
		|=> st == ecpms_pkg::ST_SETUP ##SETUP_N !strobe_n_out || !fsm_owns)
		else $error("queued byte not launched with strobe");
	a_cmd_tag: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ7]
		st == ecpms_pkg::ST_IDLE && drain_fwd && mode == ecpms_pkg::M_ECP && pop_valid
		&& !pin_s.busy && head.is_cmd |=> !autofd_n_out)
		else $error("command byte sent as data");
	a_rev_release: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ8]
		st == ecpms_pkg::ST_REV && pin_s.ack_n && fsm_owns
		|=> st == ecpms_pkg::ST_IDLE && !afd_n)
		else $error("reverse cycle not closed");
	a_epp_gate: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ9]
		##1 epp_enable_out == ($past(mode) == ecpms_pkg::M_EPP && $past(epp_sel)))
		else $error("epp enable wrong");
	a_test_quiet: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ10]
		mode == ecpms_pkg::M_TEST && st == ecpms_pkg::ST_IDLE |=> st == ecpms_pkg::ST_IDLE)
		else $error("test mode started a handshake");
	a_flags_read: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ12]
		reg_rd_in && reg_addr_in == `ECPMS_A_ECR
		|=> reg_rdata_out[1:0] == $past({!push_ready, !pop_valid}))
		else $error("full or empty flag misreported");
	a_dma_block: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ13]
		!dma_request_enable |-> !dma_req_out)
		else $error("dma request while disabled");
	a_svc_set: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ14]
		svc_evt |=> svc && port_irq_out)
		else $error("service event lost");
	a_fault_irq: assert property (@(posedge clk_in) disable iff (!rst_n) // see [RQ15]
		mode == ecpms_pkg::M_ECP && !fdis && $fell(pin_s.fault_n) |=> port_irq_out)
		else $error("fault edge gave no interrupt");
endmodule : ecpms_top

/* File: rtl/ecpms_cfg.svh */
// constants of the ecp port mode select block
// assumes one 125 MHz clock and a 3-bit register address
// Notes on behaviour
// [RQ1] mode field in bits 7..5 of extended_port_control, readable and writable
// [RQ2] mode 000 is standard port; queue held cleared while selected
// [RQ3] mode 001 lets direction bit tri-state data drivers for input
// [RQ4] mode 001 data reads return live data line levels
// [RQ5] mode 010 queues bytes and sends with compatibility handshake; host keeps direction 0
// [RQ6] ecp forward sends queued bytes with the ecp handshake
// [RQ7] ecp address bytes share the queue, sent in order as command cycles
// [RQ8] ecp reverse takes peripheral bytes into the queue for host reads
// [RQ9] mode 100 enables epp only if epp chosen in port configuration
// [RQ10] mode 110 queue is written and read, never sent out
// [RQ11] software must not write the reserved mode code
// [RQ12] bit 1 shows queue full, bit 0 queue empty, empty after reset
// [RQ13] dma requests blocked while dma enable is clear
// [RQ14] service flag set by enabled service event, cleared by software
// [RQ15] ecp mode, fault disable clear: interrupt on fault falling edge
`ifndef ECPMS_CFG_SVH
`define ECPMS_CFG_SVH
// ==========================================================
// register map
`define ECPMS_A_DATA   3'h0
`define ECPMS_A_STATUS 3'h1
`define ECPMS_A_CTRL   3'h2
`define ECPMS_A_FIFO   3'h3
`define ECPMS_A_ECR    3'h4
`define ECPMS_A_PCFG   3'h5
// ==========================================================
// mode codes
`define ECPMS_M_SPP    3'h0
`define ECPMS_M_BIDIR  3'h1
`define ECPMS_M_CFIFO  3'h2
`define ECPMS_M_ECP    3'h3
`define ECPMS_M_EPP    3'h4
`define ECPMS_M_RSVD   3'h5
`define ECPMS_M_TEST   3'h6
`define ECPMS_M_CONFIG 3'h7
// ==========================================================
// fields and reset values
`define ECPMS_ECR_FDIS  4
`define ECPMS_ECR_DMA_REQUEST_ENABLE 3
`define ECPMS_ECR_SVC   2
`define ECPMS_ECR_RESET 8'h15
`define ECPMS_C_STB     0
`define ECPMS_C_AFD     1
`define ECPMS_C_INIT    2
`define ECPMS_C_SLIN    3
`define ECPMS_C_DIR     5
`define ECPMS_CTRL_RST  6'h00
`define ECPMS_CTRL_ONES 2'h3
`define ECPMS_STAT_ONES 3'h7
`define ECPMS_CNFGA     8'h10
// ==========================================================
// timing and sizes
`define ECPMS_CLK_NS    8
`define ECPMS_SETUP_NS  500
`define ECPMS_STROBE_NS 500
`define ECPMS_CYC(ns)   (((ns) + `ECPMS_CLK_NS - 1) / `ECPMS_CLK_NS)
`define ECPMS_CNT_W     7
`define ECPMS_DEPTH     16
`define ECPMS_THRESH    8
`endif

/* File: rtl/ecpms_pkg.sv */
// types of the ecp port mode select block
// assumes ecpms_cfg.svh for the codes
`include "ecpms_cfg.svh"
package ecpms_pkg;
	typedef enum logic [2:0] {
		M_SPP    = `ECPMS_M_SPP,
		M_BIDIR  = `ECPMS_M_BIDIR,
		M_CFIFO  = `ECPMS_M_CFIFO,
		M_ECP    = `ECPMS_M_ECP,
		M_EPP    = `ECPMS_M_EPP,
		M_RSVD   = `ECPMS_M_RSVD,
		M_TEST   = `ECPMS_M_TEST,
		M_CONFIG = `ECPMS_M_CONFIG
	} ecpms_mode_t;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SETUP  = 5'h02,
		ST_STROBE = 5'h04,
		ST_HOLD   = 5'h08,
		ST_REV    = 5'h10
	} ecpms_state_t;
	typedef struct packed {
		logic       is_cmd;
		logic [7:0] data;
	} ecpms_entry_t;
	typedef struct packed {
		logic [7:0] pd;
		logic       busy;
		logic       ack_n;
		logic       fault_n;
		logic       pe;
		logic       slct;
	} ecpms_pins_t;
endpackage : ecpms_pkg

/* File: rtl/ecpms_fifo.sv */
// byte queue shared by all fifo modes
// assumes synchronous clear and a power-of-two depth
`timescale 1ns/1ps
module ecpms_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             clear_in,
	// fill side
	input  wire logic             push_valid_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	output logic                  push_ready_out,
	// drain side
	input  wire logic             pop_ready_in,
	output logic                  pop_valid_out,
	output logic [WIDTH-1:0]      pop_data_out,
	output logic [AW:0]           count_out
);
	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW-1:0]    wp, rp, next_wp, next_rp;
	logic [AW:0]      cnt, next_cnt;
	logic             do_push, do_pop;

	assign push_ready_out = (cnt != (AW+1)'(DEPTH));
	assign pop_valid_out  = (cnt != '0);
	assign pop_data_out   = mem[rp];
	assign count_out      = cnt;
	assign do_push        = push_valid_in && push_ready_out;
	assign do_pop         = pop_ready_in && pop_valid_out;

	always_comb begin
		next_mem = mem;
		next_wp  = wp;
		next_rp  = rp;
		next_cnt = cnt;
		if (clear_in) begin
			next_wp  = '0;
			next_rp  = '0;
			next_cnt = '0;
		end else begin
			if (do_push) begin
				next_mem[wp] = push_data_in;
				next_wp      = wp + 1'b1;
			end
			if (do_pop)
				next_rp = rp + 1'b1;
			if (do_push && !do_pop)
				next_cnt = cnt + 1'b1;
			else if (do_pop && !do_push)
				next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			mem <= next_mem;
			wp  <= next_wp;
			rp  <= next_rp;
			cnt <= next_cnt;
		end
	end
endmodule : ecpms_fifo

/* File: verif/ecpms_periph.sv */
// peripheral model at the far end of the port
// assumes raw active-low strobe and autofeed from the device
`timescale 1ns/1ps
module ecpms_periph #(
	parameter int DLY = 4
) (
	// clock
	input  wire logic       clk_in,
	// device pins
	input  wire logic [7:0] pd_out_in,
	input  wire logic       pd_oe_in,
	input  wire logic       strobe_n_in,
	input  wire logic       autofd_n_in,
	input  wire logic [7:0] drive_in,
	// pins to device
	output logic [7:0]      pd_in_out,
	output logic            busy_out,
	// captured {autofd_n, byte} per strobe
	output logic [8:0]      got_out [4],
	output logic [2:0]      n_got_out
);
	logic [DLY-1:0] low_sh;
	logic           stb_q;
	initial begin
		low_sh    = '0;
		stb_q     = 1'b1;
		n_got_out = 3'h0;
	end
	// busy follows strobe after DLY cycles
	assign busy_out  = low_sh[DLY-1];
	// released data lines carry the bench value
	assign pd_in_out = pd_oe_in ? pd_out_in : drive_in;
	always @(posedge clk_in) begin
		low_sh <= {low_sh[DLY-2:0], ~strobe_n_in};
		stb_q  <= strobe_n_in;
		if (stb_q && !strobe_n_in) begin
			got_out[n_got_out[1:0]] <= {autofd_n_in, pd_out_in};
			n_got_out               <= n_got_out + 3'h1;
		end
	end
endmodule : ecpms_periph

/* File: verif/ecpms_top_tb_top.sv */
// self-checking bench of the port mode select block
// assumes the peripheral model and a 125 MHz clock
`timescale 1ns/1ps
`include "ecpms_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module ecpms_top_tb_top;
	typedef struct packed {
		logic [2:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} ecpms_row_t;
	logic       clk_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic       reg_wr_in = 1'b0;
	logic       reg_rd_in = 1'b0;
	logic       dma_tc_in = 1'b0;
	logic       fault_n_in = 1'b1;
	logic       ack_n = 1'b1;
	logic [7:0] drive = 8'h00;
	logic [7:0] reg_rdata_out, pd_in, pd_out, d;
	logic       dma_req_out, pd_oe_out, strobe_n_out, autofd_n_out, busy, epp_enable_out, port_irq_out;
	logic [8:0] got [4];
	logic [2:0] n_got;
	int         n_mismatch = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         n_irq = 0;
	// no row or test ever writes mode 101
	ecpms_row_t rows [6] = '{
		'{`ECPMS_A_ECR, 8'h37, 8'h35},
		'{`ECPMS_A_ECR, 8'h96, 8'h95},
		'{`ECPMS_A_ECR, 8'h16, 8'h15},
		'{`ECPMS_A_CTRL, 8'h0A, 8'hCA},
		'{3'h7, 8'hFF, 8'h00},
		'{`ECPMS_A_ECR, 8'hD4, 8'hD5}};
	always #4 clk_in = ~clk_in;
	ecpms_top u_ecpms_top (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dma_req_out(dma_req_out),
		.dma_ack_in(1'b0), .dma_tc_in(dma_tc_in), .dma_wdata_in(8'h00), .dma_rdata_out(), .pd_in(pd_in),
		.pd_out(pd_out), .pd_oe_out(pd_oe_out), .strobe_n_out(strobe_n_out), .autofd_n_out(autofd_n_out),
		.init_n_out(), .selectin_n_out(), .busy_in(busy), .ack_n_in(ack_n), .fault_n_in(fault_n_in),
		.paper_end_in(1'b0), .select_in(1'b1), .epp_enable_out(epp_enable_out), .port_irq_out(port_irq_out));
	ecpms_periph #(.DLY(4)) u_ecpms_periph (
		.clk_in(clk_in), .pd_out_in(pd_out), .pd_oe_in(pd_oe_out), .strobe_n_in(strobe_n_out),
		.autofd_n_in(autofd_n_out), .drive_in(drive), .pd_in_out(pd_in), .busy_out(busy),
		.got_out(got), .n_got_out(n_got));
	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= w;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] r);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
		@(negedge clk_in);
		r = reg_rdata_out;
	endtask : rd
	task automatic wait_got(input logic [2:0] n);
		for (int i = 0; i < 3000 && n_got != n; i++)
			@(posedge clk_in);
		repeat (200) @(posedge clk_in);
	endtask : wait_got
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	always @(posedge clk_in) begin
		cyc++;
		if (port_irq_out === 1'b1)
			n_irq++;
		if (cyc == 12000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'h15)
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			`CHK(d, rows[i].e)
		end
		$display("table test done");
		// test mode: fill to refusal, drain in order
		for (int i = 0; i < 17; i++)
			wr(`ECPMS_A_FIFO, 8'h40 + 8'(i));
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'hD6)
		for (int i = 0; i < 16; i++) begin
			rd(`ECPMS_A_FIFO, d);
			`CHK(d, 8'h40 + 8'(i))
		end
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'hD5)
		`CHK(n_got, 3'h0)
		wr(`ECPMS_A_FIFO, 8'h77);
		wr(`ECPMS_A_ECR, 8'h14);
		wr(`ECPMS_A_ECR, 8'hD4);
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'hD5)
		$display("queue test done");
		wr(`ECPMS_A_ECR, 8'h34);
		wr(`ECPMS_A_CTRL, 8'h20);
		drive <= 8'h5A;
		repeat (4) @(posedge clk_in);
		`CHK(pd_oe_out, 1'b0)
		rd(`ECPMS_A_DATA, d);
		`CHK(d, 8'h5A)
		wr(`ECPMS_A_CTRL, 8'h00);
		repeat (2) @(posedge clk_in);
		`CHK(pd_oe_out, 1'b1)
		$display("bidir test done");
		// host keeps direction 0 in fifo modes
		wr(`ECPMS_A_ECR, 8'h54);
		wr(`ECPMS_A_FIFO, 8'h11);
		wr(`ECPMS_A_FIFO, 8'h22);
		wait_got(3'h2);
		`CHK(got[0], 9'h111)
		`CHK(got[1], 9'h122)
		wr(`ECPMS_A_ECR, 8'h74);
		wr(`ECPMS_A_DATA, 8'hA5);
		wr(`ECPMS_A_FIFO, 8'h3C);
		wait_got(3'h4);
		`CHK(got[2], 9'h0A5)
		`CHK(got[3], 9'h13C)
		$display("transfer test done");
		// ecp reverse: one byte in by ack_n, host reads it back
		wr(`ECPMS_A_CTRL, 8'h20);
		drive <= 8'hC3;
		ack_n <= 1'b0;
		repeat (6) @(posedge clk_in);
		ack_n <= 1'b1;
		repeat (6) @(posedge clk_in);
		`CHK(autofd_n_out, 1'b0)
		rd(`ECPMS_A_FIFO, d);
		`CHK(d, 8'hC3)
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'h75)
		wr(`ECPMS_A_CTRL, 8'h00);
		$display("reverse test done");
		`CHK(dma_req_out, 1'b0)
		wr(`ECPMS_A_ECR, 8'h7C);
		@(posedge clk_in);
		`CHK(dma_req_out, 1'b1)
		wr(`ECPMS_A_ECR, 8'h78);
		dma_tc_in <= 1'b1;
		@(posedge clk_in);
		dma_tc_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'h7D)
		wr(`ECPMS_A_ECR, 8'h64);
		n_irq = 0;
		fault_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		`CHK(n_irq, 1)
		fault_n_in <= 1'b1;
		wr(`ECPMS_A_ECR, 8'h74);
		repeat (6) @(posedge clk_in);
		fault_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		`CHK(n_irq, 1)
		$display("event test done");
		wr(`ECPMS_A_ECR, 8'h94);
		wr(`ECPMS_A_PCFG, 8'h00);
		repeat (3) @(posedge clk_in);
		`CHK(epp_enable_out, 1'b0)
		wr(`ECPMS_A_PCFG, 8'h01);
		repeat (3) @(posedge clk_in);
		`CHK(epp_enable_out, 1'b1)
		wr(`ECPMS_A_ECR, 8'h14);
		repeat (3) @(posedge clk_in);
		`CHK(epp_enable_out, 1'b0)
		$display("epp test done");
		// reset in mid-run with a byte queued
		wr(`ECPMS_A_ECR, 8'hD4);
		wr(`ECPMS_A_FIFO, 8'h99);
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'hD4)
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd(`ECPMS_A_ECR, d);
		`CHK(d, 8'h15)
		$display("second reset test done");
		end_sim();
	end
endmodule : ecpms_top_tb_top
